// ===== dlsa_chk.sv
// Checker for the system-access register group
`timescale 1ns/1ps
`default_nettype none
module dlsa_chk (
    input wire logic CLK_SYS,
    input wire logic NRST,
    input wire dlsa_pkg::dlsa_req_type REQ,
    input wire logic [7:0] RDATA,
    input wire logic LINK_ENABLE,
    input wire logic UROW_KEY_OK,
    input wire dlsa_pkg::dlsa_sys_type SYS,
    input wire logic SYS_RESET_REQ,
    input wire logic SYS_CLOCK_REQUEST,
    input wire logic UROW_PROGRAM_START,
    input wire logic [1:0] LINK_CLOCK_SELECT,
    input wire logic [7:0] LINK_CLOCK_MHZ
);
    default clocking @(posedge CLK_SYS); endclocking
    default disable iff (!NRST);
    logic go;
    logic en_wr;
    // Keyed done write, and any write while the link is enabled
    assign go = REQ.wr && REQ.addr == 4'hA && REQ.wdata[1] && UROW_KEY_OK;
    assign en_wr = LINK_ENABLE && REQ.wr;
    a_start_on_key: assert property (go |=> UROW_PROGRAM_START)
        else $error("start pulse missing");
    a_start_cause: assert property (UROW_PROGRAM_START |-> $past(go))
        else $error("start pulse without keyed write");
    a_system_clock_request_write: assert property (
        en_wr && REQ.addr == 4'hA ##1
        LINK_ENABLE |-> SYS_CLOCK_REQUEST == $past(REQ.wdata[0]))
        else $error("clock request differs from write");
    a_system_clock_request_off: assert property (!LINK_ENABLE |=> !SYS_CLOCK_REQUEST)
        else $error("clock request kept while disabled");
    a_system_clock_request_on: assert property ($rose(LINK_ENABLE) |-> ##[1:2] SYS_CLOCK_REQUEST)
        else $error("clock request not set on enable");
    a_sel_default: assert property (!LINK_ENABLE |=> LINK_CLOCK_SELECT == 2'h3)
        else $error("select not default while disabled");
    a_mhz_decode: assert property (
        LINK_CLOCK_MHZ == (LINK_CLOCK_SELECT == 2'h0 ?
        8'h00 : 8'h20 >> LINK_CLOCK_SELECT))
        else $error("clock decode wrong");
    a_rst_req: assert property (
        en_wr && REQ.addr == 4'h8 ##1 LINK_ENABLE |->
        SYS_RESET_REQ == ($past(REQ.wdata) == 8'h59))
        else $error("reset request differs from signature");
    c_start: cover property (UROW_PROGRAM_START);
    c_reset: cover property (SYS_RESET_REQ);
    c_enable: cover property ($rose(LINK_ENABLE));
endmodule
bind dlsa_regs dlsa_chk u_chk (.*);
`default_nettype wire

// ===== dlsa_dbg.sv
// Debugger model issuing register accesses over the link
`timescale 1ns/1ps
`default_nettype none
module dlsa_dbg (
    input wire logic clk,
    output dlsa_pkg::dlsa_req_type req
);
    // key status write ends session, outside this group
    // One access: held to the taking edge, then dropped
    task automatic acc(input logic w, input logic [3:0] a, input logic [7:0] d);
        @(posedge clk) req <= {w, !w, a, d};
        @(posedge clk) req <= '0;
        #1;
    endtask
    initial req = '0;
endmodule
`default_nettype wire

// ===== dlsa_params.svh
// Register offsets, field positions and reset values of the access group
`ifndef DLSA_PARAMS_SVH
`define DLSA_PARAMS_SVH
`define DLSA_OFS_LINK_CLOCK 4'h9
`define DLSA_OFS_SYS_CTRL 4'hA
`define DLSA_OFS_SYS_STATUS 4'hB
`define DLSA_OFS_CRC_STATUS 4'hC
`define DLSA_OFS_RESET_REQ 4'h8
`define DLSA_RST_LINK_CLOCK 2'h3
`define DLSA_RST_SYS_CTRL 2'h0
`define DLSA_RESET_SIGNATURE 8'h59
`define DLSA_BIT_CLK_REQ 0
`define DLSA_BIT_UROW_DONE 1
`define DLSA_BIT_LOCK 0
`define DLSA_BIT_UROW_PERM 2
`define DLSA_BIT_PROG_PERM 3
`define DLSA_BIT_SLEEP 4
`define DLSA_BIT_RST_ACTIVE 5
`define DLSA_CRC_OFF 3'h0
`define DLSA_CRC_BUSY 3'h1
`define DLSA_CRC_GOOD 3'h2
`define DLSA_CRC_FAIL 3'h4
`endif

// ===== dlsa_pkg.sv
// Types shared by the system-access register group
package dlsa_pkg;
    typedef enum logic [1:0] {
        DLSA_CLK_RESERVED,
        DLSA_CLK_16MHZ,
        DLSA_CLK_8MHZ,
        DLSA_CLK_4MHZ
    } dlsa_link_clk_type;
    // Register access from the link logic
    typedef struct packed {
        logic wr;
        logic rd;
        logic [3:0] addr;
        logic [7:0] wdata;
    } dlsa_req_type;
    // Live state of the system domain
    typedef struct packed {
        logic in_reset;
        logic in_sleep;
        logic prog_permitted;
        logic urow_permitted;
        logic locked;
        logic [2:0] crc_state;
    } dlsa_sys_type;
endpackage

// ===== dlsa_regs.sv
// System-access registers of the single-wire debug link
`timescale 1ns/1ps
`default_nettype none
`include "dlsa_params.svh"
module dlsa_regs (
    input wire logic CLK_SYS,
    input wire logic NRST,
    input wire dlsa_pkg::dlsa_req_type REQ,
    output logic [7:0] RDATA,
    input wire logic LINK_ENABLE,
    input wire logic UROW_KEY_OK,
    input wire dlsa_pkg::dlsa_sys_type SYS,
    output logic SYS_RESET_REQ,
    output logic SYS_CLOCK_REQUEST,
    output logic UROW_PROGRAM_START,
    output logic [1:0] LINK_CLOCK_SELECT,
    output logic [7:0] LINK_CLOCK_MHZ
);
    logic [1:0] clk_sel_r, clk_sel_nxt;
    logic clk_req_r, clk_req_nxt;
    logic urow_done_r, urow_done_nxt;
    logic rst_req_r, rst_req_nxt;
    logic rst_seen_r, rst_seen_nxt;
    logic lock_r, lock_nxt;
    logic en_d_r;
    logic [7:0] rdata_r, rdata_nxt;
    logic [7:0] status;
    logic [2:0] crc_field;

    // Decode a write strobe to one offset, used by each writable register
    function automatic logic wr_hit(input dlsa_pkg::dlsa_req_type q,
                                    input logic [3:0] ofs);
        wr_hit = q.wr && (q.addr == ofs);
    endfunction

    // The reserved select code maps to zero rather than a guessed rate
    function automatic logic [7:0] sel_mhz(input logic [1:0] s);
        unique case (dlsa_pkg::dlsa_link_clk_type'(s))
            dlsa_pkg::DLSA_CLK_16MHZ: sel_mhz = 8'h10;
            dlsa_pkg::DLSA_CLK_8MHZ: sel_mhz = 8'h08;
            dlsa_pkg::DLSA_CLK_4MHZ: sel_mhz = 8'h04;
            dlsa_pkg::DLSA_CLK_RESERVED: sel_mhz = 8'h00;
        endcase
    endfunction

    // Non-one-hot CRC codes are reported as not enabled
    always_comb begin
        unique case (SYS.crc_state)
            `DLSA_CRC_BUSY, `DLSA_CRC_GOOD, `DLSA_CRC_FAIL:
                crc_field = SYS.crc_state;
            default: crc_field = `DLSA_CRC_OFF;
        endcase
    end

    // Status byte assembly, reserved bits held at zero
    always_comb begin
        status = 8'h00;
        status[`DLSA_BIT_RST_ACTIVE] = rst_seen_r;
        status[`DLSA_BIT_SLEEP] = SYS.in_sleep;
        status[`DLSA_BIT_PROG_PERM] = SYS.prog_permitted;
        status[`DLSA_BIT_UROW_PERM] = SYS.urow_permitted;
        status[`DLSA_BIT_LOCK] = lock_r;
    end

    // Next state of control registers
    always_comb begin
        clk_sel_nxt = clk_sel_r;
        clk_req_nxt = clk_req_r;
        urow_done_nxt = 1'b0;
        rst_req_nxt = rst_req_r;
        rst_seen_nxt = rst_seen_r;
        lock_nxt = SYS.locked;
        rdata_nxt = rdata_r;
        if (wr_hit(REQ, `DLSA_OFS_LINK_CLOCK)) begin
            clk_sel_nxt = REQ.wdata[1:0];
        end
        if (wr_hit(REQ, `DLSA_OFS_SYS_CTRL)) begin
            clk_req_nxt = REQ.wdata[`DLSA_BIT_CLK_REQ];
            if (UROW_KEY_OK) begin
                urow_done_nxt = REQ.wdata[`DLSA_BIT_UROW_DONE];
            end
        end
        if (wr_hit(REQ, `DLSA_OFS_RESET_REQ)) begin
            rst_req_nxt = (REQ.wdata == `DLSA_RESET_SIGNATURE);
        end
        // read clears, but live reset sets again
        if (REQ.rd && REQ.addr == `DLSA_OFS_SYS_STATUS) begin
            rst_seen_nxt = 1'b0;
        end
        if (SYS.in_reset || rst_req_r) begin
            rst_seen_nxt = 1'b1;
        end
        // enable edge sets clock request and restores select default, disable clears request
        if (!LINK_ENABLE) begin
            clk_req_nxt = 1'b0;
            clk_sel_nxt = `DLSA_RST_LINK_CLOCK;
            rst_req_nxt = 1'b0;
        end else if (!en_d_r) begin
            clk_req_nxt = 1'b1;
            clk_sel_nxt = `DLSA_RST_LINK_CLOCK;
        end
        if (REQ.rd) begin
            unique case (REQ.addr)
                `DLSA_OFS_LINK_CLOCK: rdata_nxt = {6'h00, clk_sel_r};
                `DLSA_OFS_SYS_CTRL: rdata_nxt = {7'h00, clk_req_r};
                `DLSA_OFS_SYS_STATUS: rdata_nxt = status;
                `DLSA_OFS_CRC_STATUS: rdata_nxt = {5'h00, crc_field};
                default: rdata_nxt = 8'h00;
            endcase
        end
    end

    // Register stage
    always_ff @(posedge CLK_SYS or negedge NRST) begin
        if (!NRST) begin
            clk_sel_r <= `DLSA_RST_LINK_CLOCK;
            clk_req_r <= 1'b0;
            urow_done_r <= 1'b0;
            rst_req_r <= 1'b0;
            rst_seen_r <= 1'b0;
            lock_r <= 1'b1;
            en_d_r <= 1'b0;
            rdata_r <= 8'h00;
        end else begin
            clk_sel_r <= clk_sel_nxt;
            clk_req_r <= clk_req_nxt;
            urow_done_r <= urow_done_nxt;
            rst_req_r <= rst_req_nxt;
            rst_seen_r <= rst_seen_nxt;
            lock_r <= lock_nxt;
            en_d_r <= LINK_ENABLE;
            rdata_r <= rdata_nxt;
        end
    end

    assign RDATA = rdata_r;
    assign SYS_RESET_REQ = rst_req_r;
    assign SYS_CLOCK_REQUEST = clk_req_r;
    assign UROW_PROGRAM_START = urow_done_r;
    assign LINK_CLOCK_SELECT = clk_sel_r;
    assign LINK_CLOCK_MHZ = sel_mhz(clk_sel_r);
endmodule
`default_nettype wire

// ===== testbench.sv
// Self-checking bench for the system-access register group
`timescale 1ns/1ps
`default_nettype none
module testbench;
    logic clk = 0, nrst = 0, en = 1, key = 0, rq, cr, st;
    dlsa_pkg::dlsa_req_type req;
    dlsa_pkg::dlsa_sys_type sys = 8'h08;
    logic [7:0] rd, mhz, x, lf = 8'h24;
    logic [1:0] sel;
    int err_count = 0, check_count = 0, rf = 0, v;
    dlsa_regs dut (.CLK_SYS(clk), .NRST(nrst), .REQ(req), .RDATA(rd),
        .LINK_ENABLE(en), .UROW_KEY_OK(key), .SYS(sys), .SYS_RESET_REQ(rq),
        .SYS_CLOCK_REQUEST(cr), .UROW_PROGRAM_START(st),
        .LINK_CLOCK_SELECT(sel), .LINK_CLOCK_MHZ(mhz));
    dlsa_dbg dbg (.clk(clk), .req(req));
    initial forever #2.5 clk = ~clk;
    // Shift register source of random bytes
    task automatic rnd();
        lf = {lf[6:0], lf[7] ^ lf[5] ^ lf[4] ^ lf[3]};
        x = lf;
    endtask
    task automatic chk(input logic [7:0] g, input logic [7:0] e);
        check_count++;
        if (g !== e) begin
            err_count++;
            $display("unexpected at %0t: got %h want %h", $time, g, e);
        end
    endtask
    task automatic rr(input logic [3:0] a, input logic [7:0] e);
        dbg.acc(0, a, 8'h00);
        chk(rd, e);
    endtask
    task automatic results();
        if (err_count == 0 && check_count > 0) $display("Simulation passed");
        else $display("Simulation failed");
        $finish;
    endtask
    // Watchdog well past the expected run
    initial begin
        #20us;
        err_count++;
        results();
    end
    initial begin
        repeat (10) @(posedge clk);
        nrst <= 1;
        rr(4'hB, 8'h01);
        rr(4'h9, 8'h03);
        rr(4'hA, 8'h01);
        // brown-out taken as highest, fast clocks allowed
        for (v = 0; v < 4; v++) begin
            rnd();
            dbg.acc(1, 4'h9, {x[7:2], v[1:0]});
            rr(4'h9, v[7:0]);
            chk(mhz, v ? 8'h20 >> v : 8'h00);
        end
        dbg.acc(1, 4'hA, 8'h03);
        chk({st, cr}, 8'h01);
        @(posedge clk) key <= 1;
        // row data taken as loaded before the done write
        dbg.acc(1, 4'hA, 8'h02);
        chk({st, cr}, 8'h02);
        rr(4'hA, 8'h00);
        @(posedge clk) en <= 0;
        dbg.acc(1, 4'h9, 8'h01);
        chk({cr, sel}, 8'h03);
        @(posedge clk) en <= 1;
        repeat (3) @(posedge clk);
        #1 chk({cr, sel}, 8'h07);
        dbg.acc(1, 4'h8, 8'h59);
        chk(rq, 8'h01);
        rr(4'hB, 8'h21);
        rnd();
        dbg.acc(1, 4'h8, x == 8'h59 ? 8'h00 : x);
        chk(rq, 8'h00);
        rr(4'hB, 8'h21);
        for (v = 0; v < 8; v++) begin
            rnd();
            @(posedge clk) sys <= {x[7:3], v[2:0]};
            dbg.acc(1, 4'hB, ~x);
            rf = rf | x[7];
            // programming and user row flags follow system
            // user row permission shown in bit two
            rr(4'hB, {2'h0, rf[0], x[6:4], 1'b0, x[3]});
            rf = x[7];
            rr(4'hC, v inside {0, 1, 2, 4} ? v[7:0] : 8'h00);
        end
        dbg.acc(1, 4'hF, x);
        rr(4'hF, 8'h00);
        results();
    end
endmodule
`default_nettype wire
